// [bench/cp15_cache_select_sysctl_regs_tb_top.sv]
// self-checking bench for the coprocessor register group
`timescale 1ns/1ps
module cp15_cache_select_sysctl_regs_tb_top;
    logic                   ref_clk;
    logic                   rst_b;
    sysctl_pkg::cop_req_t   cop_req;
    logic                   priv_mode;
    logic                   non_secure;
    logic                   exception_entry;
    logic                   exception_state_reset_pin;
    logic                   secure_reg_write_disable;
    sysctl_pkg::cop_resp_t  cop_resp;
    logic                   status_endianness_bit;
    logic                   status_endianness_load;
    sysctl_pkg::sctl_bits_t sctl_secure;
    sysctl_pkg::sctl_bits_t sctl_non_secure;
    logic                   walk_big_endian;
    logic                   geometry_instr_selected;
    int                     num_errors;
    int                     samples_checked;

    cp15_cache_select_sysctl_regs cp15_cache_select_sysctl_regs_inst (.ref_clk, .rst_b, .cop_req,
        .priv_mode, .non_secure, .exception_entry, .exception_state_reset_pin,
        .secure_reg_write_disable, .cop_resp, .status_endianness_bit, .status_endianness_load,
        .sctl_secure, .sctl_non_secure, .walk_big_endian, .geometry_instr_selected);

    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp)
        begin
            num_errors++;
            $display("FAIL %s expected %h seen %h", name, exp, got);
        end
    endtask : check

    // one access, answer sampled in the cycle it stands
    task automatic access(input logic wr, input logic [2:0] o1, input logic [3:0] cn,
        input logic [2:0] o2, input logic [31:0] wd, input logic und, input string name,
        input logic [31:0] exp);
        @(posedge ref_clk);
        #1 cop_req = '{1'b1, wr, o1, cn, 4'h0, o2, wd};
        @(posedge ref_clk);
        #1 cop_req.valid = 1'b0;
        check({name, "_valid"}, 32'h1, {31'h0, cop_resp.valid});
        check({name, "_undef"}, {31'h0, und}, {31'h0, cop_resp.undef});
        if (!wr)
            check(name, exp, cop_resp.rdata);
    endtask : access

    task automatic pulse_exception(input logic ee);
        exception_entry = 1'b1;
        @(posedge ref_clk);
        #1 exception_entry = 1'b0;
        check("ee_load", 32'h1, {31'h0, status_endianness_load});
        check("exception_endianness", {31'h0, ee}, {31'h0, status_endianness_bit});
        check("walk_ee", {31'h0, ee}, {31'h0, walk_big_endian});
    endtask : pulse_exception

    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : complete_run

    initial
    begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end

    initial
    begin
        repeat (2000) @(posedge ref_clk);
        num_errors++;
        complete_run();
    end

    initial
    begin
        num_errors = 0;
        samples_checked = 0;
        cop_req = '0;
        priv_mode = 1'b1;
        non_secure = 1'b0;
        exception_entry = 1'b0;
        exception_state_reset_pin = 1'b1;
        secure_reg_write_disable = 1'b0;
        rst_b = 1'b0;
        repeat (10) @(posedge ref_clk);
        #1 rst_b = 1'b1;
        repeat (3) @(posedge ref_clk);
        access(0, 0, 1, 0, 0, 0, "sctl_rst", 32'h40C4_0000);
        access(1, 0, 1, 0, 32'hFFFF_FFFF, 0, "sctl_wr", 0);
        access(0, 0, 1, 0, 0, 0, "sctl_s", 32'h72C4_0000);
        check("bank_s", 32'h0000_000F, {28'h0, sctl_secure});
        check("bank_ns", 32'h0000_0008, {28'h0, sctl_non_secure});
        pulse_exception(1'b1);
        non_secure = 1'b1;
        access(0, 0, 1, 0, 0, 0, "sctl_ns", 32'h40C4_0000);
        pulse_exception(1'b0);
        priv_mode = 1'b0;
        access(0, 0, 1, 0, 0, 1, "user_rd", 0);
        access(1, 0, 1, 0, 0, 1, "user_wr", 0);
        access(0, 1, 0, 7, 0, 1, "user_aux", 0);
        access(0, 2, 0, 0, 0, 1, "user_csel", 0);
        priv_mode = 1'b1;
        non_secure = 1'b0;
        secure_reg_write_disable = 1'b1;
        repeat (3) @(posedge ref_clk);
        access(1, 0, 1, 0, 0, 1, "locked_wr", 0);
        access(0, 0, 1, 0, 0, 0, "locked_rd", 32'h72C4_0000);
        secure_reg_write_disable = 1'b0;
        access(0, 1, 0, 7, 0, 0, "aux_s", 0);
        access(1, 2, 0, 0, 32'hFFFF_FFFF, 0, "csel_wr", 0);
        access(0, 2, 0, 0, 0, 0, "csel_s", 32'h1);
        check("geom_s", 32'h1, {31'h0, geometry_instr_selected});
        non_secure = 1'b1;
        access(0, 1, 0, 7, 0, 0, "aux_ns", 0);
        access(0, 2, 0, 0, 0, 0, "csel_ns", 0);
        check("geom_ns", 32'h0, {31'h0, geometry_instr_selected});
        access(1, 2, 0, 0, 32'h0000_000E, 0, "csel_ns_wr", 0);
        access(0, 2, 0, 0, 0, 0, "csel_ns_rd", 0);
        non_secure = 1'b0;
        access(0, 2, 0, 0, 0, 0, "csel_s_kept", 32'h1);
        complete_run();
    end
endmodule : cp15_cache_select_sysctl_regs_tb_top

// [bench/cp15_regs_monitor.sv]
// port checker for the coprocessor register group
`timescale 1ns/1ps
module cp15_regs_monitor (
    input wire logic                   ref_clk,
    input wire logic                   rst_b,
    input wire sysctl_pkg::cop_req_t   cop_req,
    input wire logic                   priv_mode,
    input wire logic                   non_secure,
    input wire logic                   exception_entry,
    input wire sysctl_pkg::cop_resp_t  cop_resp,
    input wire logic                   status_endianness_bit,
    input wire logic                   status_endianness_load,
    input wire sysctl_pkg::sctl_bits_t sctl_secure,
    input wire sysctl_pkg::sctl_bits_t sctl_non_secure
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_b);
    logic rd;
    logic at_c0;
    logic is_sys;
    assign rd = cop_req.valid && !cop_req.write && priv_mode;
    assign at_c0 = cop_req.crn == 4'h0 && cop_req.crm == 4'h0;
    assign is_sys = cop_req.crn == 4'h1 && cop_req.crm == 4'h0 && cop_req.opc1 == 3'h0
                    && cop_req.opc2 == 3'h0;
    resp_pulse_a: assert property (cop_req.valid |=> cop_resp.valid)
        else $error("no answer one cycle after request");
    user_undef_a: assert property (cop_req.valid && !priv_mode && is_sys |=> cop_resp.undef)
        else $error("user access not refused");
    aux_zero_a: assert property (rd && at_c0 && cop_req.opc1 == 3'h1 && cop_req.opc2 == 3'h7
        |=> cop_resp.rdata == 32'h0000_0000 && !cop_resp.undef) else $error("aux id not zero");
    level_zero_a: assert property (rd && at_c0 && cop_req.opc1 == 3'h2 && cop_req.opc2 == 3'h0
        |=> cop_resp.rdata[31:1] == 31'h0000_0000) else $error("cache level not zero");
    fixed_bits_a: assert property (rd && is_sys
        |=> (cop_resp.rdata & 32'h8DFE_0000) == 32'h00C4_0000) else $error("fixed bits wrong");
    refused_zero_a: assert property (cop_resp.undef |-> cop_resp.rdata == 32'h0000_0000)
        else $error("refused access returned data");
    ee_load_a: assert property (exception_entry |=> status_endianness_load)
        else $error("no endianness load after exception");
    ee_copy_a: assert property (exception_entry && !$past(cop_req.valid)
        |=> status_endianness_bit == $past(non_secure ? sctl_non_secure.ee : sctl_secure.ee))
        else $error("endianness copy wrong");
    cover property (cop_req.valid && !priv_mode);
    cover property (cop_resp.undef && $past(priv_mode));
    cover property (exception_entry && non_secure);
endmodule : cp15_regs_monitor

bind cp15_cache_select_sysctl_regs cp15_regs_monitor cp15_regs_monitor_inst (.ref_clk, .rst_b,
    .cop_req, .priv_mode, .non_secure, .exception_entry, .cop_resp, .status_endianness_bit,
    .status_endianness_load, .sctl_secure, .sctl_non_secure);

// [core/cp15_cache_select_sysctl_regs.sv]
// coprocessor register group: aux id, cache select, system control upper half
// Operation
// - aux id reads all zero
// - aux id at opcode1 1, c0 c0, opcode2 7
// - privileged only; aux id shared
// - cache select banked per security state
// - cache level field reads zero
// - bit 0 picks instruction or data
// - cache select at opcode1 2, c0 c0, 0
// - cache select drives geometry select output
// - user mode access is undefined
// - secure system control write with disable pin is undefined
// - writes to read-only bits ignored
// - system control banked, no stored bits shared
// - bit 30 exception state, reset from pin
// - bit 29 access flag enable, resets 0
// - bit 28 attribute remap enable, resets 0
// - bit 25 copied to status endianness
// - table walks use exception endianness
// - bit 17 reads zero, writes ignored
// - geometry top nibble 0010 instr, 0111 data
`timescale 1ns/1ps
`include "sysctl_consts.svh"

module cp15_cache_select_sysctl_regs (
    input  wire logic                  ref_clk,
    input  wire logic                  rst_b,
    input  wire sysctl_pkg::cop_req_t  cop_req,
    input  wire logic                  priv_mode,
    input  wire logic                  non_secure,
    input  wire logic                  exception_entry,
    input  wire logic                  exception_state_reset_pin,
    input  wire logic                  secure_reg_write_disable,
    output sysctl_pkg::cop_resp_t      cop_resp,
    output logic                       status_endianness_bit,
    output logic                       status_endianness_load,
    output sysctl_pkg::sctl_bits_t     sctl_secure,
    output sysctl_pkg::sctl_bits_t     sctl_non_secure,
    output logic                       walk_big_endian,
    output logic                       geometry_instr_selected
);

    // pin inputs pass two flip-flops
    logic                   te_pin_meta;
    logic                   te_pin_sync;
    logic                   wdis_meta;
    logic                   wdis_sync;
    logic                   was_reset;
    logic                   csel_s;
    logic                   csel_ns;
    sysctl_pkg::sctl_bits_t bank_s;
    sysctl_pkg::sctl_bits_t bank_ns;
    sysctl_pkg::reg_sel_t   sel;
    logic                   is_user;
    logic                   undef_now;
    logic                   wr_ok;
    logic                   cur_csel;
    sysctl_pkg::sctl_bits_t cur_bank;
    logic [31:0]            next_rdata;
    logic [31:0]            geometry_word;

    // synchronisers run through reset so the pin value is settled at release
    always_ff @(posedge ref_clk)
    begin
        te_pin_meta <= exception_state_reset_pin;
        te_pin_sync <= te_pin_meta;
        wdis_meta   <= secure_reg_write_disable;
        wdis_sync   <= wdis_meta;
    end

    // decode
    always_comb
    begin
        sel = sysctl_pkg::SEL_NONE;
        if (cop_req.crn == `CRN_ID && cop_req.crm == `CRM_ZERO
            && cop_req.opc1 == `OPC1_AUX_ID && cop_req.opc2 == `OPC2_AUX_ID
            && !cop_req.write)
        begin
            sel = sysctl_pkg::SEL_AUX_ID;
        end
        else if (cop_req.crn == `CRN_ID && cop_req.crm == `CRM_ZERO
            && cop_req.opc1 == `OPC1_CSEL && cop_req.opc2 == `OPC2_CSEL)
        begin
            sel = sysctl_pkg::SEL_CSEL;
        end
        else if (cop_req.crn == `CRN_SYSCTL && cop_req.crm == `CRM_ZERO
            && cop_req.opc1 == `OPC1_SYSCTL && cop_req.opc2 == `OPC2_SYSCTL)
        begin
            sel = sysctl_pkg::SEL_SYSCTL;
        end
    end

    assign is_user   = !priv_mode;
    // user mode and disabled secure system control writes are refused
    assign undef_now = cop_req.valid && (sel != sysctl_pkg::SEL_NONE) && (is_user
                       || (sel == sysctl_pkg::SEL_SYSCTL && cop_req.write
                           && !non_secure && wdis_sync));
    assign wr_ok     = cop_req.valid && cop_req.write && !undef_now;
    assign cur_csel  = non_secure ? csel_ns : csel_s;
    assign cur_bank  = non_secure ? bank_ns : bank_s;

    // cache select copies, only bit 0 stored
    always_ff @(posedge ref_clk)
    begin
        if (!rst_b)
        begin
            csel_s  <= 1'b0;
            csel_ns <= 1'b0;
        end
        else if (wr_ok && sel == sysctl_pkg::SEL_CSEL)
        begin
            if (non_secure)
                csel_ns <= cop_req.wdata[`CSEL_INSTR_BIT];
            else
                csel_s  <= cop_req.wdata[`CSEL_INSTR_BIT];
        end
    end

    // system control banks; compact-state bit loads from pin after reset
    always_ff @(posedge ref_clk)
    begin
        if (!rst_b)
        begin
            was_reset <= 1'b1;
            bank_s    <= '0;
            bank_ns   <= '0;
        end
        else if (was_reset)
        begin
            was_reset <= 1'b0;
            bank_s.te  <= te_pin_sync;
            bank_ns.te <= te_pin_sync;
        end
        else if (wr_ok && sel == sysctl_pkg::SEL_SYSCTL)
        begin
            // only writable bits are taken
            if (non_secure)
            begin
                bank_ns.te  <= cop_req.wdata[`SCTL_TE_BIT];
                bank_ns.afe <= cop_req.wdata[`SCTL_AFE_BIT];
                bank_ns.attr_remap_enable <= cop_req.wdata[`SCTL_TRE_BIT];
                bank_ns.ee  <= cop_req.wdata[`SCTL_EXCEPTION_ENDIANNESS];
            end
            else
            begin
                bank_s.te  <= cop_req.wdata[`SCTL_TE_BIT];
                bank_s.afe <= cop_req.wdata[`SCTL_AFE_BIT];
                bank_s.attr_remap_enable <= cop_req.wdata[`SCTL_TRE_BIT];
                bank_s.ee  <= cop_req.wdata[`SCTL_EXCEPTION_ENDIANNESS];
            end
        end
    end

    // geometry word for the selected cache
    always_comb
    begin
        if (cur_csel)
            geometry_word = {`GEOM_TOP_INSTR, `GEOM_NSETS_INSTR, `GEOM_ASSOC_INSTR,
                             `GEOM_LINE};
        else
            geometry_word = {`GEOM_TOP_DATA, `GEOM_NSETS_DATA, `GEOM_ASSOC_DATA,
                             `GEOM_LINE};
    end

    // read data
    always_comb
    begin
        next_rdata = `WORD_ZERO;
        case (sel)
            sysctl_pkg::SEL_AUX_ID: next_rdata = `WORD_ZERO;
            sysctl_pkg::SEL_CSEL:
            begin
                next_rdata[`CSEL_INSTR_BIT] = cur_csel;
            end
            sysctl_pkg::SEL_SYSCTL:
            begin
                next_rdata = `SCTL_FIXED_ONES;
                next_rdata[`SCTL_TE_BIT]  = cur_bank.te;
                next_rdata[`SCTL_AFE_BIT] = cur_bank.afe;
                next_rdata[`SCTL_TRE_BIT] = cur_bank.attr_remap_enable;
                next_rdata[`SCTL_EXCEPTION_ENDIANNESS]  = cur_bank.ee;
            end
            default: next_rdata = `WORD_ZERO;
        endcase
    end

    // response, one cycle after the request
    always_ff @(posedge ref_clk)
    begin
        if (!rst_b)
            cop_resp <= '0;
        else
        begin
            cop_resp.valid <= cop_req.valid;
            cop_resp.undef <= undef_now;
            cop_resp.rdata <= (cop_req.valid && !cop_req.write && !undef_now)
                              ? next_rdata : `WORD_ZERO;
        end
    end

    // exception endianness to status and walker, cache select to geometry select
    always_ff @(posedge ref_clk)
    begin
        if (!rst_b)
        begin
            status_endianness_bit   <= 1'b0;
            status_endianness_load  <= 1'b0;
            walk_big_endian         <= 1'b0;
            geometry_instr_selected <= 1'b0;
            sctl_secure             <= '0;
            sctl_non_secure         <= '0;
        end
        else
        begin
            status_endianness_load  <= exception_entry;
            if (exception_entry)
                status_endianness_bit <= cur_bank.ee;
            walk_big_endian         <= cur_bank.ee;
            geometry_instr_selected <= cur_csel;
            sctl_secure             <= bank_s;
            sctl_non_secure         <= bank_ns;
        end
    end

endmodule : cp15_cache_select_sysctl_regs

// [core/sysctl_consts.svh]
// constants for the cache-select and system-control register group
`ifndef SYSCTL_CONSTS_SVH
`define SYSCTL_CONSTS_SVH
`define OPC1_AUX_ID        3'h1
`define OPC2_AUX_ID        3'h7
`define OPC1_CSEL          3'h2
`define OPC2_CSEL          3'h0
`define OPC1_SYSCTL        3'h0
`define OPC2_SYSCTL        3'h0
`define CRN_ID             4'h0
`define CRN_SYSCTL         4'h1
`define CRM_ZERO           4'h0
`define CSEL_INSTR_BIT     0
`define SCTL_TE_BIT        30
`define SCTL_AFE_BIT       29
`define SCTL_TRE_BIT       28
`define SCTL_EXCEPTION_ENDIANNESS        25
`define SCTL_FIXED_ONES    32'h00C4_0000
`define GEOM_TOP_INSTR     4'h2
`define GEOM_TOP_DATA      4'h7
`define GEOM_NSETS_INSTR   15'h007F
`define GEOM_NSETS_DATA    15'h003F
`define GEOM_ASSOC_INSTR   10'h001
`define GEOM_ASSOC_DATA    10'h003
`define GEOM_LINE          3'h1
`define WORD_ZERO          32'h0000_0000
`endif

// [core/sysctl_pkg.sv]
// types for the cache-select and system-control register group
package sysctl_pkg;
    typedef struct packed {
        logic        valid;
        logic        write;
        logic [2:0]  opc1;
        logic [3:0]  crn;
        logic [3:0]  crm;
        logic [2:0]  opc2;
        logic [31:0] wdata;
    } cop_req_t;

    typedef struct packed {
        logic        valid;
        logic        undef;
        logic [31:0] rdata;
    } cop_resp_t;

    typedef struct packed {
        logic te;
        logic afe;
        logic attr_remap_enable;
        logic ee;
    } sctl_bits_t;

    typedef enum logic [1:0] {
        SEL_NONE,
        SEL_AUX_ID,
        SEL_CSEL,
        SEL_SYSCTL
    } reg_sel_t;
endpackage : sysctl_pkg
